/* File: bench/cpd_exec_chk.sv */
// Port-level checks for the execution unit
module cpd_exec_chk (
	input wire i_clk, // Clock
	input wire i_sys_rst, // Reset
	input wire i_issue, // Issue
	input wire [31:0] i_insn, // Instruction
	input wire [31:0] i_pc, // Its address
	input wire [31:0] i_psw, // Status in
	input wire o_busy, // Busy
	input wire o_done, // Done
	input wire o_mem_req, // Stack read
	input wire [31:0] o_mem_addr, // Stack address
	input wire o_rf_we, // Register write
	input wire o_sp_we, // SP write
	input wire o_psw_we, // Status write
	input wire [31:0] o_psw_wdata, // Status out
	input wire o_jump, // Branch
	input wire [31:0] o_jump_pc, // Branch target
	input wire o_restart, // Restart
	input wire [31:0] o_ret_pc, // Return address
	input wire o_irq_take, // Interrupt taken
	input wire o_clk_stop // Clock gated
);
	timeunit 1ns;
	timeprecision 1ns;
	wire take = i_issue && !o_busy;
	wire is_div = take && i_insn[10:5] == 6'h3F && i_insn[26:23] == 4'b0101;
	logic [31:0] pc_r;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Address of the last accepted instruction
	always @(posedge i_clk) if (take) pc_r <= i_pc;
	property p_ei;
		take && i_insn == 32'h016087E0 |=> o_psw_we && o_done
			&& o_psw_wdata == ($past(i_psw) & ~32'h20);
	endproperty
	a_ei: assert property (p_ei) else $error("unmask result wrong");
	property p_ei_quiet;
		take && i_insn == 32'h016087E0 |=> !o_irq_take;
	endproperty
	a_ei_quiet: assert property (p_ei_quiet) else $error("irq taken on unmask");
	property p_halt;
		take && i_insn == 32'h012007E0 |=> o_clk_stop;
	endproperty
	a_halt: assert property (p_halt) else $error("halt did not gate");
	property p_wake_pc;
		o_irq_take |-> o_ret_pc == pc_r + 32'h4;
	endproperty
	a_wake_pc: assert property (p_wake_pc) else $error("wake return wrong");
	property p_restart;
		o_restart |-> o_ret_pc == pc_r && !o_rf_we && !o_sp_we;
	endproperty
	a_restart: assert property (p_restart) else $error("restart wrong");
	property p_align;
		o_mem_req |-> o_mem_addr[1:0] == 2'b00;
	endproperty
	a_align: assert property (p_align) else $error("stack address unaligned");
	property p_jump;
		o_jump |-> !o_jump_pc[0] && o_done;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong");
	property p_div_end;
		is_div |-> ##[1:40] (o_done || o_restart);
	endproperty
	a_div_end: assert property (p_div_end) else $error("divide never ended");
endmodule // cpd_exec_chk
bind cpd_exec cpd_exec_chk u_chk (.i_clk, .i_sys_rst, .i_issue, .i_insn, .i_pc, .i_psw,
	.o_busy, .o_done, .o_mem_req, .o_mem_addr, .o_rf_we, .o_sp_we, .o_psw_we, .o_psw_wdata,
	.o_jump, .o_jump_pc, .o_restart, .o_ret_pc, .o_irq_take, .o_clk_stop);

/* File: bench/cpd_stack_mem.sv */
// Stack memory model that answers word reads after a set delay
module cpd_stack_mem (
	input wire logic i_clk, // CPU clock
	input wire logic i_req, // Read request
	input wire logic [31:0] i_addr, // Read address
	input wire logic [3:0] i_lat, // Idle cycles before the answer
	output logic o_ack = 1'b0, // Word returned
	output logic [31:0] o_rdata = 32'h0 // Word, the address inverted
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] addr_r;
	logic [3:0] cnt_r = 4'h0;
	logic pend_r = 1'b0;
	// Requests while pending or in the answer cycle repeat the last one and are ignored
	always @(posedge i_clk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_req && !pend_r && !o_ack) begin
			pend_r <= 1'b1;
			addr_r <= i_addr;
			cnt_r <= i_lat;
		end else if (pend_r && cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end else if (pend_r) begin
			pend_r <= 1'b0;
			o_ack <= 1'b1;
			o_rdata <= ~addr_r;
		end
	end
endmodule // cpd_stack_mem

/* File: bench/tb.sv */
// Self-checking bench for the execution unit with a stack memory model
`define CK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [10:0] sub; logic [4:0] w; logic [31:0] a, b, q, r;
		logic [2:0] f, fm; logic cq;} cpd_row_t;
	localparam logic [31:0] EIW = 32'h016087E0;
	localparam logic [31:0] HALTW = 32'h012007E0;
	localparam logic [31:0] DIVW = {5'd7, 11'h2C0, 5'd6, 6'h3F, 5'd3};
	localparam logic [31:0] POPW = {11'b10001000001, 5'd0, 10'h019, 5'd3, 1'b0};
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_issue = 1'b0, i_irq = 1'b0, i_nmi = 1'b0;
	logic [31:0] i_insn = 32'h0, i_pc = 32'h0, i_rs1 = 32'h0, i_rs2 = 32'h0, i_psw = 32'h0;
	logic [31:0] i_sp = 32'h1002;
	logic [3:0] lat = 4'h0;
	wire i_mem_ack, o_busy, o_done, o_mem_req, o_rf_we, o_sp_we, o_psw_we, o_jump;
	wire o_restart, o_irq_take, o_clk_stop;
	wire [31:0] i_mem_rdata, o_mem_addr, o_rf_wdata, o_sp_wdata, o_psw_wdata, o_jump_pc, o_ret_pc;
	wire [4:0] o_rf_waddr;
	int error_cnt = 0, checks = 0;
	cpd_row_t r;
	logic [4:0] pr [4] = '{5'd31, 5'd30, 5'd24, 5'd20};
	cpd_row_t rows [9] = '{
		'{11'h2C0, 7, 100, 32'hFFFFFFF9, 32'hFFFFFFF2, 2, 3'b010, 3'b111, 1},
		'{11'h2C0, 7, 32'h80000000, 32'hFFFFFFFF, 32'h80000000, 0, 3'b110, 3'b111, 1},
		'{11'h2C0, 7, 5, 0, 0, 0, 3'b100, 3'b100, 0},
		'{11'h2C2, 7, 32'hFFFFFFF0, 32'h10, 32'h0FFFFFFF, 0, 3'b000, 3'b111, 1},
		'{11'h2C2, 7, 32'h80000000, 32'hFFFFFFFF, 0, 32'h80000000, 3'b001, 3'b111, 1},
		'{11'h2C2, 6, 7, 9, 0, 7, 3'b001, 3'b111, 1},
		'{11'h2C2, 7, 5, 0, 0, 0, 3'b100, 3'b100, 0},
		'{11'h282, 7, 32'h12345, 32'hFFFF0010, 32'h1234, 5, 3'b000, 3'b111, 1},
		'{11'h280, 7, 32'hFFFFFF9C, 32'h1234FFF9, 14, 32'hFFFFFFFE, 3'b000, 3'b111, 1}};
	cpd_exec dut (.*);
	cpd_stack_mem mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr), .i_lat(lat),
		.o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	initial forever #10 i_clk = ~i_clk;
	// Waits until idle, then presents one instruction for one clock
	task issue(input logic [31:0] ins, b, a, program_status_word);
		repeat (50) if (o_busy) @(negedge i_clk);
		@(posedge i_clk);
		i_issue <= 1'b1;
		i_insn <= ins;
		i_rs1 <= b;
		i_rs2 <= a;
		i_psw <= program_status_word;
		i_pc <= i_pc + 32'h100;
		@(posedge i_clk);
		i_issue <= 1'b0;
		@(negedge i_clk);
	endtask
	task nxt_we;
		repeat (60) if (!o_rf_we) @(negedge i_clk);
	endtask
	task conclude;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		conclude;
	end
	// Divide table, then pops, aborts, unmask, halt wakes and reset
	initial begin
		repeat (12) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(negedge i_clk);
		`CK({o_busy, o_clk_stop, o_done}, 3'b000)
		foreach (rows[k]) begin
			r = rows[k];
			issue({r.w, r.sub, 5'd6, 6'h3F, 5'd3}, r.b, r.a, 32'h18);
			nxt_we;
			`CK({o_rf_we, o_rf_waddr}, {1'b1, 5'd6})
			if (r.cq) `CK(o_rf_wdata, r.q)
			`CK({o_psw_we, o_psw_wdata[4:0] & {2'b11, r.fm}}, {3'b111, r.f & r.fm})
			@(negedge i_clk);
			nxt_we;
			`CK({o_done, o_rf_waddr}, {1'b1, r.w})
			if (r.cq) `CK(o_rf_wdata, r.r)
		end
		// Two-operand halfword divide, quotient into r6, no remainder write
		issue({16'h0000, 5'd6, 6'h02, 5'd3}, 32'hFFFF0003, 32'h64, 32'h18);
		nxt_we;
		`CK({o_rf_we, o_done, o_rf_waddr, o_rf_wdata}, {2'b11, 5'd6, 32'h21})
		@(negedge i_clk);
		`CK(o_rf_we, 1'b0)
		// Plain pop, then the jump form that also selects r30
		for (int j = 0; j < 2; j++) begin
			lat <= 4'(j * 3);
			issue({11'b10001000001, j ? 5'd5 : 5'd0, 10'h019, 5'd3, j[0]}, 32'h2001, 0, 0);
			for (int n = 0; n < 3 + j; n++) begin
				nxt_we;
				`CK({o_rf_we, o_rf_waddr, o_rf_wdata}, {1'b1, pr[n + (n && !j)], ~(32'h100C + n * 4)})
				@(negedge i_clk);
			end
			repeat (20) if (!o_sp_we) @(negedge i_clk);
			`CK({o_sp_we, o_done, o_jump, o_sp_wdata}, {2'b11, j[0], 32'h101A + 32'(j * 4)})
			if (j) `CK(o_jump_pc, 32'h2000)
		end
		for (int m = 0; m < 3; m++) begin
			@(posedge i_clk) i_irq <= (m < 2);
			issue(m ? DIVW : POPW, 32'h3, 32'h9, 0);
			// A request pending at issue is answered at once; otherwise abort mid-divide
			if (m == 2) begin
				repeat (10) @(posedge i_clk);
				i_irq <= 1'b1;
				repeat (40) if (!o_restart) @(negedge i_clk);
			end
			`CK({o_restart, o_ret_pc, o_rf_we, o_sp_we}, {1'b1, i_pc, 2'b00})
			@(posedge i_clk) i_irq <= 1'b0;
		end
		issue(EIW, 0, 0, 32'h3F);
		repeat (3) if (!o_psw_we) @(negedge i_clk);
		`CK({o_psw_we, o_done, o_irq_take, o_psw_wdata}, {3'b110, 32'h1F})
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk) i_irq <= !k;
			issue(HALTW, 0, 0, k ? 32'h0 : 32'h20);
			repeat (6) @(negedge i_clk);
			`CK(o_clk_stop, 1'b1)
			@(posedge i_clk);
			i_nmi <= !k;
			i_irq <= 1'b1;
			repeat (8) if (!o_irq_take) @(negedge i_clk);
			`CK({o_irq_take, o_ret_pc}, {1'b1, i_pc + 32'h4})
			@(posedge i_clk);
			i_nmi <= 1'b0;
			i_irq <= 1'b0;
		end
		issue(HALTW, 0, 0, 32'h20);
		@(posedge i_clk) i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(negedge i_clk);
		`CK({o_clk_stop, o_busy}, 2'b00)
		conclude;
	end
endmodule // tb

/* File: hw/cpd_divider.v */
// Iterative 32-by-32 restoring divider, signed or unsigned, with abort
`include "cpd_defs.vh"
module cpd_divider #(
	parameter WIDTH = 32
) (
	input wire i_clk, // CPU clock
	input wire i_sys_rst, // Synchronous reset
	input wire i_start, // Start pulse
	input wire i_abort, // Abandon current division
	input wire i_signed, // Signed operands
	input wire [WIDTH-1:0] i_dividend, // Dividend
	input wire [WIDTH-1:0] i_divisor, // Divisor
	output reg o_done, // One-cycle result pulse
	output reg [WIDTH-1:0] o_quot, // Quotient
	output reg [WIDTH-1:0] o_rem // Remainder
);
	reg busy_r;
	reg [5:0] cnt_r;
	reg [WIDTH-1:0] q_r;
	reg [WIDTH-1:0] r_r;
	reg [WIDTH-1:0] d_r;
	reg qneg_r;
	reg rneg_r;
	wire [WIDTH:0] trial;
	wire [WIDTH-1:0] a_abs;
	wire [WIDTH-1:0] b_abs;
	assign a_abs = (i_signed && i_dividend[WIDTH-1]) ? (~i_dividend + 1'b1) : i_dividend;
	assign b_abs = (i_signed && i_divisor[WIDTH-1]) ? (~i_divisor + 1'b1) : i_divisor;
	assign trial = {r_r, q_r[WIDTH-1]} - {1'b0, d_r};
	// Shift-subtract one quotient bit per cycle
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_sys_rst || i_abort) begin
			busy_r <= 1'b0;
			cnt_r <= 6'd0;
			q_r <= {WIDTH{1'b0}};
			r_r <= {WIDTH{1'b0}};
			d_r <= {WIDTH{1'b0}};
			qneg_r <= 1'b0;
			rneg_r <= 1'b0;
			if (i_sys_rst) begin
				o_quot <= {WIDTH{1'b0}};
				o_rem <= {WIDTH{1'b0}};
			end
		end else if (i_start) begin
			busy_r <= 1'b1;
			cnt_r <= 6'd0;
			q_r <= a_abs;
			r_r <= {WIDTH{1'b0}};
			d_r <= b_abs;
			qneg_r <= i_signed && (i_dividend[WIDTH-1] ^ i_divisor[WIDTH-1]);
			rneg_r <= i_signed && i_dividend[WIDTH-1];
		end else if (busy_r) begin
			if (cnt_r == `CPD_DIV_CYCLES - 6'd1) begin
				busy_r <= 1'b0;
				o_done <= 1'b1;
				o_quot <= qneg_r ? (~q_r + 1'b1) : q_r;
				o_rem <= rneg_r ? (~r_r + 1'b1) : r_r;
			end else begin
				cnt_r <= cnt_r + 6'd1;
				if (!trial[WIDTH]) begin
					r_r <= trial[WIDTH-1:0];
					q_r <= {q_r[WIDTH-2:0], 1'b1};
				end else begin
					r_r <= {r_r[WIDTH-2:0], q_r[WIDTH-1]};
					q_r <= {q_r[WIDTH-2:0], 1'b0};
				end
			end
		end
	end
endmodule // cpd_divider

/* File: hw/cpd_exec.v */
// Execution unit: stack-frame release, divides, interrupt unmask and halt
`include "cpd_defs.vh"
module cpd_exec (
	input wire i_clk, // CPU clock
	input wire i_sys_rst, // Core reset
	input wire i_issue, // Instruction valid pulse
	input wire [31:0] i_insn, // Instruction, low halfword in [15:0]
	input wire [31:0] i_pc, // Address of this instruction
	input wire [31:0] i_sp, // Current stack pointer
	input wire [31:0] i_rs1, // reg1 value (divisor or jump target)
	input wire [31:0] i_rs2, // reg2 value (dividend)
	input wire [31:0] i_mem_rdata, // Stack read data
	input wire i_mem_ack, // Stack read complete
	input wire i_irq, // Maskable request pending
	input wire i_nmi, // Non-maskable request
	input wire [31:0] i_psw, // Current program_status_word
	output reg o_busy, // Instruction in progress
	output reg o_done, // Instruction completed pulse
	output reg o_mem_req, // Stack read request
	output reg [31:0] o_mem_addr, // Stack read address
	output reg o_rf_we, // Register write strobe
	output reg [4:0] o_rf_waddr, // Register write index
	output reg [31:0] o_rf_wdata, // Register write data
	output reg o_sp_we, // Stack pointer write strobe
	output reg [31:0] o_sp_wdata, // New stack pointer
	output reg o_psw_we, // PROGRAM_STATUS_WORD write strobe
	output reg [31:0] o_psw_wdata, // New program_status_word
	output reg o_jump, // Branch pulse
	output reg [31:0] o_jump_pc, // Branch target
	output reg o_restart, // Aborted, restart from o_ret_pc
	output reg [31:0] o_ret_pc, // Return address for interrupt
	output reg o_irq_take, // Interrupt accepted pulse
	output reg o_clk_stop // CPU clock gate off while halted
);
	localparam S_IDLE = 3'd0;
	localparam S_POP = 3'd1;
	localparam S_DIV = 3'd2;
	localparam S_WQ = 3'd3;
	localparam S_HALT = 3'd4;
	reg [2:0] st_r;
	reg [31:0] insn_r;
	reg [31:0] pc_r;
	reg [31:0] sp_r;
	reg [31:0] mask_r;
	reg [31:0] jmp_r;
	reg [31:0] q_r;
	reg [31:0] psw_r;
	reg div_go;
	reg div_abort;
	wire div_done;
	wire [31:0] div_q;
	wire [31:0] div_rem;
	// Pop mask bit that carries register n
	function [4:0] map_bit;
		input [4:0] n;
		begin
			case (n)
				5'd20: map_bit = 5'd27;
				5'd21: map_bit = 5'd26;
				5'd22: map_bit = 5'd25;
				5'd23: map_bit = 5'd24;
				5'd24: map_bit = 5'd31;
				5'd25: map_bit = 5'd30;
				5'd26: map_bit = 5'd29;
				5'd27: map_bit = 5'd28;
				5'd28: map_bit = 5'd23;
				5'd29: map_bit = 5'd22;
				5'd30: map_bit = 5'd0;
				default: map_bit = 5'd21;
			endcase
		end
	endfunction
	// Highest still-selected register, r31 down to r20
	reg [4:0] pop_reg;
	reg pop_any;
	integer k;
	always @* begin
		pop_reg = 5'd0;
		pop_any = 1'b0;
		for (k = 20; k <= 31; k = k + 1) begin
			if (mask_r[map_bit(k[4:0])]) begin
				pop_reg = k[4:0];
				pop_any = 1'b1;
			end
		end
	end
	// Decode
	wire [10:0] hi_sub = i_insn[26:16];
	wire is_fmt11 = (i_insn[10:5] == 6'h3F);
	wire is_pop = (i_insn[15:6] == `CPD_POP_LO_PFX);
	wire is_div = is_fmt11 && (hi_sub == `CPD_DIV_SUB);
	wire is_unsigned_word_quotient = is_fmt11 && (hi_sub == `CPD_UNSIGNED_WORD_QUOTIENT_SUB);
	wire is_unsigned_half_quotient = is_fmt11 && (hi_sub == `CPD_UNSIGNED_HALF_QUOTIENT_SUB);
	wire is_divh3 = is_fmt11 && (hi_sub == `CPD_DIVH3_SUB);
	wire is_divh2 = (i_insn[10:5] == 6'h02) && (i_insn[15:11] != 5'd0)
		&& (i_insn[4:0] != 5'd0);
	wire is_sys = (i_insn[10:0] == `CPD_SYS_LO);
	wire is_ei = is_sys && (i_insn[15:11] == `CPD_EI_LO5) && (i_insn[31:16] == `CPD_EI_HI);
	wire is_halt = is_sys && (i_insn[15:11] == 5'd0) && (i_insn[31:16] == `CPD_HALT_HI);
	wire any_div = is_div || is_unsigned_word_quotient || is_unsigned_half_quotient || is_divh3 || is_divh2;
	wire half_op = is_unsigned_half_quotient || is_divh3 || is_divh2;
	wire sgn_op = is_div || is_divh3 || is_divh2;
	wire [31:0] dvs = half_op ? (sgn_op ? {{16{i_rs1[15]}}, i_rs1[15:0]}
		: {16'h0000, i_rs1[15:0]}) : i_rs1;
	wire wake = i_nmi || (i_irq && !i_psw[`CPD_PSW_ID]);
	// Divide flags: wrap from divisor and dividend, sign and zero from final quotient
	reg [31:0] fl;
	reg ovf;
	always @* begin
		ovf = 1'b0;
		if (jmp_r == 32'h00000000)
			ovf = 1'b1;
		else if (psw_r[31] && q_r == `CPD_MOST_NEG && jmp_r == 32'hFFFFFFFF)
			ovf = 1'b1;
		fl = {1'b0, psw_r[30:0]}; // Carry and clamp_flag kept
		fl[`CPD_PSW_WRAP] = ovf;
		fl[`CPD_PSW_SIGN] = div_q[31];
		fl[`CPD_PSW_ZERO] = (div_q == 32'h00000000);
	end
	cpd_divider #(.WIDTH(32)) u_div (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_start(div_go),
		.i_abort(div_abort),
		.i_signed(sgn_op),
		.i_dividend(i_rs2),
		.i_divisor(dvs),
		.o_done(div_done),
		.o_quot(div_q),
		.o_rem(div_rem)
	);
	// Start and abort strobes to the divider
	always @* begin
		div_go = (st_r == S_IDLE) && i_issue && any_div && !i_irq && !i_nmi;
		div_abort = (st_r == S_DIV) && (i_irq || i_nmi);
	end
	// Main sequencer
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		o_rf_we <= 1'b0;
		o_sp_we <= 1'b0;
		o_psw_we <= 1'b0;
		o_jump <= 1'b0;
		o_restart <= 1'b0;
		o_irq_take <= 1'b0;
		o_mem_req <= 1'b0;
		if (i_sys_rst) begin
			st_r <= S_IDLE;
			insn_r <= 32'h00000000;
			pc_r <= 32'h00000000;
			sp_r <= 32'h00000000;
			mask_r <= 32'h00000000;
			jmp_r <= 32'h00000000;
			q_r <= 32'h00000000;
			psw_r <= 32'h00000000;
			o_busy <= 1'b0;
			o_mem_addr <= 32'h00000000;
			o_rf_waddr <= 5'd0;
			o_rf_wdata <= 32'h00000000;
			o_sp_wdata <= 32'h00000000;
			o_psw_wdata <= 32'h00000000;
			o_jump_pc <= 32'h00000000;
			o_ret_pc <= 32'h00000000;
			o_clk_stop <= 1'b0;
		end else begin
			case (st_r)
				S_IDLE: begin
					if (i_issue) begin
						insn_r <= i_insn;
						pc_r <= i_pc;
						psw_r <= {sgn_op, i_psw[30:0]};
						if (is_pop && (i_irq || i_nmi)) begin
							o_restart <= 1'b1; // SP untouched
							o_ret_pc <= i_pc;
						end else if (is_pop) begin
							sp_r <= i_sp + {25'd0, i_insn[5:1], 2'b00};
							// Bits 20-1 are dropped; r30 rides in the low halfword
							mask_r <= {i_insn[31:21], 20'h00000, i_insn[0]};
							jmp_r <= {i_rs1[31:1], 1'b0};
							o_busy <= 1'b1;
							st_r <= S_POP;
						end else if (any_div && (i_irq || i_nmi)) begin
							o_restart <= 1'b1;
							o_ret_pc <= i_pc;
						end else if (any_div) begin
							q_r <= i_rs2;
							jmp_r <= dvs;
							o_busy <= 1'b1;
							st_r <= S_DIV;
						end else if (is_ei) begin
							o_psw_we <= 1'b1; // Sampling held off this cycle
							o_psw_wdata <= i_psw & ~(32'h1 << `CPD_PSW_ID);
							o_done <= 1'b1;
						end else if (is_halt) begin
							o_clk_stop <= 1'b1;
							o_ret_pc <= i_pc + `CPD_WORD_STEP;
							o_busy <= 1'b1;
							st_r <= S_HALT;
						end
					end
				end
				S_POP: begin
					if (!pop_any) begin
						o_sp_we <= 1'b1;
						o_sp_wdata <= sp_r;
						o_jump <= (insn_r[20:16] != 5'd0);
						o_jump_pc <= jmp_r;
						o_done <= 1'b1;
						o_busy <= 1'b0;
						st_r <= S_IDLE;
					end else if (i_mem_ack) begin
						o_rf_we <= 1'b1; // Each pop commits as it lands
						o_rf_waddr <= pop_reg;
						o_rf_wdata <= i_mem_rdata;
						sp_r <= sp_r + `CPD_WORD_STEP;
						mask_r[map_bit(pop_reg)] <= 1'b0;
					end else begin
						o_mem_req <= 1'b1;
						o_mem_addr <= {sp_r[31:2], 2'b00};
					end
				end
				S_DIV: begin
					if (div_abort) begin
						o_restart <= 1'b1; // Nothing written yet
						o_ret_pc <= pc_r;
						o_busy <= 1'b0;
						st_r <= S_IDLE;
					end else if (div_done) begin
						o_psw_we <= 1'b1;
						o_psw_wdata <= {1'b0, fl[30:0]};
						o_rf_we <= 1'b1;
						o_rf_waddr <= insn_r[15:11]; // Quotient to dividend reg
						o_rf_wdata <= (psw_r[31] && q_r == `CPD_MOST_NEG
							&& jmp_r == 32'hFFFFFFFF) ? `CPD_MOST_NEG : div_q;
						if (insn_r[10:5] == 6'h02) begin
							o_done <= 1'b1; // No remainder
							o_busy <= 1'b0;
							st_r <= S_IDLE;
						end else begin
							st_r <= S_WQ;
						end
					end
				end
				S_WQ: begin
					o_rf_we <= 1'b1; // Written last so it wins on same reg
					o_rf_waddr <= insn_r[31:27];
					o_rf_wdata <= div_rem;
					o_done <= 1'b1;
					o_busy <= 1'b0;
					st_r <= S_IDLE;
				end
				S_HALT: begin
					if (wake) begin
						o_clk_stop <= 1'b0;
						o_irq_take <= 1'b1;
						o_busy <= 1'b0;
						st_r <= S_IDLE;
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule // cpd_exec

/* File: inc/cpd_defs.vh */
// Constants for the pop, divide, interrupt-unmask and halt execution unit
`ifndef CPD_DEFS_VH
`define CPD_DEFS_VH
`define CPD_POP_LO_PFX 10'h019
`define CPD_DIV_SUB 11'h2C0
`define CPD_UNSIGNED_WORD_QUOTIENT_SUB 11'h2C2
`define CPD_UNSIGNED_HALF_QUOTIENT_SUB 11'h282
`define CPD_DIVH3_SUB 11'h280
`define CPD_DIVH2_LO 6'h00
`define CPD_SYS_LO 11'h7E0
`define CPD_EI_LO5 5'h10
`define CPD_HALT_HI 16'h0120
`define CPD_EI_HI 16'h0160
`define CPD_MOST_NEG 32'h80000000
`define CPD_WORD_STEP 32'h00000004
`define CPD_PSW_ID 5
`define CPD_PSW_WRAP 2
`define CPD_PSW_SIGN 1
`define CPD_PSW_ZERO 0
`define CPD_DIV_CYCLES 6'd33
`endif
